// ==== core/charger_pkg.sv ====
package charger_pkg;

	// register indices on the internal register port
	localparam logic [7:0] ADDR_TIMER_COLD = 8'h05;
	localparam logic [7:0] ADDR_COMP_THERMAL = 8'h08;
	localparam logic [7:0] ADDR_OPT_SWITCH = 8'h09;
	localparam logic [7:0] ADDR_RESERVED = 8'h0a;
	localparam logic [7:0] ADDR_MISC_CTRL = 8'h14;

	// values after reset
	localparam logic [7:0] RST_TIMER_COLD = 8'h9d;
	localparam logic [7:0] RST_COMP_THERMAL = 8'h03;
	localparam logic [7:0] RST_OPT_SWITCH = 8'h44;
	localparam logic [7:0] RST_MISC_CTRL = 8'h00;

	// writable bits, and bits that watchdog expiry restores
	localparam logic [7:0] WMASK_TIMER_COLD = 8'hbf;
	localparam logic [7:0] WDOG_MASK_OPT = 8'hd3;

	// field positions
	localparam int TERM_EN_BIT = 7;
	localparam int WD_LSB = 4;
	localparam int TMR_EN_BIT = 3;
	localparam int FCT_LSB = 1;
	localparam int COLD_BIT = 0;
	localparam int RES_LSB = 5;
	localparam int CLAMP_LSB = 2;
	localparam int THERMAL_REG_THRESHOLD_LSB = 0;
	localparam int FORCE_BIT = 7;
	localparam int SLOW_BIT = 6;
	localparam int SHIP_BIT = 5;
	localparam int HOT_BIT = 4;
	localparam int SHIP_DLY_BIT = 3;
	localparam int FSR_BIT = 2;
	localparam int UP_BIT = 1;
	localparam int DN_BIT = 0;
	localparam int REG_RST_BIT = 7;
	localparam int PULSE_EN_BIT = 0;

	// timing
	localparam longint SEC_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 5;
	localparam int SEC_CYCLES_DEF = int'(SEC_NS / CLK_PERIOD_NS);
	localparam logic [7:0] WD_40_S = 8'h28;
	localparam logic [7:0] WD_80_S = 8'h50;
	localparam logic [7:0] WD_160_S = 8'ha0;
	localparam logic [7:0] SHIP_DLY_S_DEF = 8'h0a;

	// analog scale figures
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] PCT_COLD_50 = 8'h32;
	localparam logic [7:0] PCT_COLD_20 = 8'h14;
	localparam logic [7:0] THERMAL_REG_THRESHOLD_BASE_C = 8'h3c;
	localparam logic [7:0] HOT_DROP_MV = 8'hc8;

	function automatic logic [7:0] wd_period_s(input logic [1:0] code);
		logic [7:0] s;
		s = 8'h00;
		case (code)
			2'b01: s = WD_40_S;
			2'b10: s = WD_80_S;
			2'b11: s = WD_160_S;
			default: s = 8'h00;
		endcase
		return s;
	endfunction : wd_period_s

endpackage : charger_pkg

// ==== core/wd_if.sv ====
`timescale 1ns/100ps
interface wd_if;
	logic kick;
	logic [1:0] period;
	logic expire;
	logic sec_tick;

	modport bank (output kick, output period, input expire, input sec_tick);
	modport timer (input kick, input period, output expire, output sec_tick);
endinterface : wd_if

// ==== core/host_watchdog.sv ====
`timescale 1ns/100ps
module host_watchdog
	import charger_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
)
(
	// clock and synchronised reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// link to the register bank
	wd_if.timer wd
);

	logic [31:0] pre_r;
	logic [7:0] sec_r;
	logic tick_r;
	logic expire_r;
	logic [7:0] limit;

	assign limit = wd_period_s(wd.period);
	assign wd.sec_tick = tick_r;
	assign wd.expire = expire_r;

	////////////////////////////////////////////////////////////////
	// one-second enable; free running so ship delay keeps its pace
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pre_r <= 32'h0;
			tick_r <= 1'b0;
		end
		else if (pre_r == 32'(SEC_CYCLES - 1))
		begin
			pre_r <= 32'h0;
			tick_r <= 1'b1;
		end
		else
		begin
			pre_r <= pre_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// seconds since last host access; >= so a shortened period bites
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sec_r <= 8'h0;
			expire_r <= 1'b0;
		end
		else if (wd.kick || limit == 8'h0)
		begin
			sec_r <= 8'h0;
			expire_r <= 1'b0;
		end
		else if (tick_r && (sec_r + 8'h1) >= limit)
		begin
			sec_r <= 8'h0;
			expire_r <= 1'b1;
		end
		else
		begin
			if (tick_r)
				sec_r <= sec_r + 8'h1;
			expire_r <= 1'b0;
		end
	end

endmodule : host_watchdog

// ==== core/charger_control_register_bank.sv ====
`timescale 1ns/100ps
// Function
// - watchdog period code 10 gives 80 s, code 11 gives 160 s
// - safety timer enable bit: 0 disables, 1 enables, resets to 1
// - cold band current is 50% of setting when bit 0, 20% when 1
// - compensation resistance weights 80/40/20 mOhm, 0 to 140, reset 0
// - compensation clamp weights 128/64/32 mV, 0 to 224, reset 0
// - thermal threshold codes 60/80/100/120 C, reset code 11
// - writing 1 starts optimizer; bit clears once optimization starts
// - slowdown bit halves safety timer rate during power limiting or thermal
// - ship bit forces switch off; only register reset restores it
// - ship mode switch off immediately, or after delay when delay bit set
// - full system reset through switch allowed when 1, inhibited when 0
// - hot band voltage is target minus 200 mV when 0, full when 1
// - pulse up settable only with pulse enable; cleared at sequence end
// - pulse down settable only with pulse enable; cleared at sequence end
// - dual-source fields restore on register reset or watchdog expiry
// - register reset restores all, resets safety timer, then self-clears
module charger_control_register_bank
	import charger_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DEF,
	parameter logic [7:0] SHIP_DLY_S = SHIP_DLY_S_DEF
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// register port from the serial front end
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// analog status levels
	input wire logic i_band_cold,
	input wire logic i_band_hot,
	input wire logic i_power_limiting,
	input wire logic i_thermal_reg,
	input wire logic i_optimizer_started,
	input wire logic i_pulse_done,
	// controls to the analog side
	output logic o_charge_term_enable,
	output logic [1:0] o_fast_charge_time_limit,
	output logic [7:0] o_watchdog_period_s,
	output logic o_watchdog_expired,
	output logic o_safety_timer_enable,
	output logic o_safety_timer_half_rate,
	output logic o_safety_timer_reset,
	output logic [7:0] o_charge_current_pct,
	output logic [7:0] o_comp_resistance_mohm,
	output logic [7:0] o_comp_voltage_clamp_mv,
	output logic [7:0] o_thermal_reg_threshold_c,
	output logic [7:0] o_charge_voltage_drop_mv,
	output logic o_force_optimizer_start,
	output logic o_battery_switch_off,
	output logic o_full_system_reset_enable,
	output logic o_pulse_up_request,
	output logic o_pulse_down_request
);

	localparam int NSYNC = 6;

	logic rst_meta;
	logic rst_n;
	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] sync_meta;
	logic [NSYNC-1:0] sync_q;
	logic cold_s;
	logic hot_s;
	logic plim_s;
	logic therm_s;
	logic opt_started_s;
	logic pulse_done_s;

	logic [7:0] timer_r;
	logic [7:0] comp_r;
	logic [7:0] opt_r;
	logic pulse_en_r;
	logic reg_rst_r;
	logic [7:0] ship_cnt_r;
	logic [7:0] opt_nxt;

	logic wr_timer;
	logic wr_comp;
	logic wr_opt;
	logic wr_misc;
	logic wd_expire;

	wd_if wd ();

	////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// analog levels are asynchronous to this clock
	assign sync_in = {i_band_cold, i_band_hot, i_power_limiting,
		i_thermal_reg, i_optimizer_started, i_pulse_done};

	for (genvar g = 0; g < NSYNC; g++)
	begin : g_sync
		always_ff @(posedge i_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				sync_meta[g] <= 1'b0;
				sync_q[g] <= 1'b0;
			end
			else
			begin
				sync_meta[g] <= sync_in[g];
				sync_q[g] <= sync_meta[g];
			end
		end
	end

	assign {cold_s, hot_s, plim_s, therm_s, opt_started_s, pulse_done_s} =
		sync_q;

	////////////////////////////////////////////////////////////////
	// decode and watchdog
	assign wr_timer = i_reg_wr && i_reg_addr == ADDR_TIMER_COLD;
	assign wr_comp = i_reg_wr && i_reg_addr == ADDR_COMP_THERMAL;
	assign wr_opt = i_reg_wr && i_reg_addr == ADDR_OPT_SWITCH;
	assign wr_misc = i_reg_wr && i_reg_addr == ADDR_MISC_CTRL;

	assign wd.kick = i_reg_wr || i_reg_rd || reg_rst_r;
	assign wd.period = timer_r[WD_LSB+1:WD_LSB];
	assign wd_expire = wd.expire;

	host_watchdog #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_watchdog (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.wd(wd.timer)
	);

	////////////////////////////////////////////////////////////////
	// register reset request: one cycle visible, then self-clears
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rst_r <= 1'b0;
		else if (reg_rst_r)
			reg_rst_r <= 1'b0;
		else if (wr_misc)
			reg_rst_r <= i_reg_wdata[REG_RST_BIT];
	end

	////////////////////////////////////////////////////////////////
	// timer and cold current register; bit 6 is reserved
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_r <= RST_TIMER_COLD;
		else if (reg_rst_r || wd_expire)
			timer_r <= RST_TIMER_COLD;
		else if (wr_timer)
			timer_r <= i_reg_wdata & WMASK_TIMER_COLD;
	end

	////////////////////////////////////////////////////////////////
	// compensation and thermal register
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			comp_r <= RST_COMP_THERMAL;
		else if (reg_rst_r || wd_expire)
			comp_r <= RST_COMP_THERMAL;
		else if (wr_comp)
			comp_r <= i_reg_wdata;
	end

	////////////////////////////////////////////////////////////////
	// pulse control enable
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_en_r <= RST_MISC_CTRL[PULSE_EN_BIT];
		else if (reg_rst_r || wd_expire)
			pulse_en_r <= RST_MISC_CTRL[PULSE_EN_BIT];
		else if (wr_misc)
			pulse_en_r <= i_reg_wdata[PULSE_EN_BIT];
	end

	////////////////////////////////////////////////////////////////
	// optimizer and switch register; a software set beats a
	// same-cycle completion so no request is lost
	always_comb
	begin
		opt_nxt = opt_r;
		if (opt_started_s)
			opt_nxt[FORCE_BIT] = 1'b0;
		if (pulse_done_s)
		begin
			opt_nxt[UP_BIT] = 1'b0;
			opt_nxt[DN_BIT] = 1'b0;
		end
		if (wr_opt)
		begin
			opt_nxt[SLOW_BIT] = i_reg_wdata[SLOW_BIT];
			opt_nxt[SHIP_BIT] = i_reg_wdata[SHIP_BIT];
			opt_nxt[HOT_BIT] = i_reg_wdata[HOT_BIT];
			opt_nxt[SHIP_DLY_BIT] = i_reg_wdata[SHIP_DLY_BIT];
			opt_nxt[FSR_BIT] = i_reg_wdata[FSR_BIT];
			if (i_reg_wdata[FORCE_BIT])
				opt_nxt[FORCE_BIT] = 1'b1;
			if (i_reg_wdata[UP_BIT] && pulse_en_r)
				opt_nxt[UP_BIT] = 1'b1;
			if (i_reg_wdata[DN_BIT] && pulse_en_r)
				opt_nxt[DN_BIT] = 1'b1;
		end
		if (wd_expire)
			opt_nxt = (opt_nxt & ~WDOG_MASK_OPT) |
				(RST_OPT_SWITCH & WDOG_MASK_OPT);
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			opt_r <= RST_OPT_SWITCH;
		else if (reg_rst_r)
			opt_r <= RST_OPT_SWITCH;
		else
			opt_r <= opt_nxt;
	end

	////////////////////////////////////////////////////////////////
	// ship mode delay, counted in whole seconds; clearing the ship
	// bit during the wait cancels the turn-off
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			ship_cnt_r <= 8'h0;
		else if (!opt_r[SHIP_BIT])
			ship_cnt_r <= 8'h0;
		else if (wd.sec_tick && ship_cnt_r != SHIP_DLY_S)
			ship_cnt_r <= ship_cnt_r + 8'h1;
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_battery_switch_off <= 1'b0;
		else
			o_battery_switch_off <= opt_r[SHIP_BIT] &&
				(!opt_r[SHIP_DLY_BIT] ||
				ship_cnt_r == SHIP_DLY_S);
	end

	////////////////////////////////////////////////////////////////
	// decoded controls toward the analog loops
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_charge_term_enable <= 1'b0;
			o_fast_charge_time_limit <= 2'b00;
			o_watchdog_period_s <= 8'h0;
			o_safety_timer_enable <= 1'b0;
			o_safety_timer_half_rate <= 1'b0;
			o_charge_current_pct <= PCT_FULL;
			o_comp_resistance_mohm <= 8'h0;
			o_comp_voltage_clamp_mv <= 8'h0;
			o_thermal_reg_threshold_c <= THERMAL_REG_THRESHOLD_BASE_C;
			o_charge_voltage_drop_mv <= 8'h0;
			o_full_system_reset_enable <= 1'b0;
		end
		else
		begin
			o_charge_term_enable <= timer_r[TERM_EN_BIT];
			o_fast_charge_time_limit <= timer_r[FCT_LSB+1:FCT_LSB];
			o_watchdog_period_s <=
				wd_period_s(timer_r[WD_LSB+1:WD_LSB]);
			o_safety_timer_enable <= timer_r[TMR_EN_BIT];
			o_safety_timer_half_rate <= timer_r[TMR_EN_BIT] &&
				opt_r[SLOW_BIT] && (plim_s || therm_s);
			if (!cold_s)
				o_charge_current_pct <= PCT_FULL;
			else if (timer_r[COLD_BIT])
				o_charge_current_pct <= PCT_COLD_20;
			else
				o_charge_current_pct <= PCT_COLD_50;
			o_comp_resistance_mohm <=
				{1'b0, comp_r[RES_LSB+:3], 4'h0} +
				{3'h0, comp_r[RES_LSB+:3], 2'h0};
			o_comp_voltage_clamp_mv <=
				{comp_r[CLAMP_LSB+:3], 5'h0};
			o_thermal_reg_threshold_c <= THERMAL_REG_THRESHOLD_BASE_C +
				{2'h0, comp_r[THERMAL_REG_THRESHOLD_LSB+:2], 4'h0} +
				{4'h0, comp_r[THERMAL_REG_THRESHOLD_LSB+:2], 2'h0};
			o_charge_voltage_drop_mv <=
				(hot_s && !opt_r[HOT_BIT]) ? HOT_DROP_MV : 8'h0;
			o_full_system_reset_enable <= opt_r[FSR_BIT];
		end
	end

	assign o_force_optimizer_start = opt_r[FORCE_BIT];
	assign o_pulse_up_request = opt_r[UP_BIT];
	assign o_pulse_down_request = opt_r[DN_BIT];
	assign o_watchdog_expired = wd_expire;
	assign o_safety_timer_reset = reg_rst_r;

	////////////////////////////////////////////////////////////////
	// read port, one cycle latency, unmapped reads 0
	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_reg_rdata <= 8'h0;
		else if (i_reg_rd)
		begin
			case (i_reg_addr)
				ADDR_TIMER_COLD: o_reg_rdata <= timer_r;
				ADDR_COMP_THERMAL: o_reg_rdata <= comp_r;
				ADDR_OPT_SWITCH: o_reg_rdata <= opt_r;
				ADDR_MISC_CTRL: o_reg_rdata <= {reg_rst_r, 6'h0,
					pulse_en_r};
				default: o_reg_rdata <= 8'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_rst_req;
		wr_misc && i_reg_wdata[REG_RST_BIT] && !reg_rst_r;
	endsequence

	sequence s_rst_done;
		reg_rst_r ##1 (!reg_rst_r && timer_r == RST_TIMER_COLD &&
			opt_r == RST_OPT_SWITCH && comp_r == RST_COMP_THERMAL);
	endsequence

	property p_wd_80;
		timer_r[WD_LSB+1:WD_LSB] == 2'b10 |=> o_watchdog_period_s == 8'h50;
	endproperty
	a_wd_80: assert property (p_wd_80)
		else $error("watchdog period not 80 s");

	property p_timer_default;
		reg_rst_r |=> ##1 o_safety_timer_enable;
	endproperty
	a_timer_default: assert property (p_timer_default)
		else $error("safety timer not enabled after reset");

	property p_cold_20;
		cold_s && timer_r[COLD_BIT] |=> o_charge_current_pct == 8'h14;
	endproperty
	a_cold_20: assert property (p_cold_20)
		else $error("cold band current not 20 percent");

	property p_comp_res;
		##1 o_comp_resistance_mohm == 8'h14 * $past(comp_r[7:5]);
	endproperty
	a_comp_res: assert property (p_comp_res)
		else $error("compensation resistance wrong");

	property p_thermal_reg_threshold_default;
		wd_expire |=> ##1 o_thermal_reg_threshold_c == 8'h78;
	endproperty
	a_thermal_reg_threshold_default: assert property (p_thermal_reg_threshold_default)
		else $error("thermal threshold not 120 C after expiry");

	property p_force_set;
		wr_opt && i_reg_wdata[FORCE_BIT] && !reg_rst_r && !wd_expire
			|=> o_force_optimizer_start;
	endproperty
	a_force_set: assert property (p_force_set)
		else $error("optimizer request not set");

	property p_ship_keep;
		wd_expire && !reg_rst_r && !wr_opt |=> $stable(opt_r[SHIP_BIT]);
	endproperty
	a_ship_keep: assert property (p_ship_keep)
		else $error("ship bit changed by watchdog");

	property p_ship_now;
		opt_r[SHIP_BIT] && !opt_r[SHIP_DLY_BIT] |=> o_battery_switch_off;
	endproperty
	a_ship_now: assert property (p_ship_now)
		else $error("switch not off at once");

	property p_up_gated;
		wr_opt && i_reg_wdata[UP_BIT] && !pulse_en_r && !opt_r[UP_BIT]
			|=> !o_pulse_up_request;
	endproperty
	a_up_gated: assert property (p_up_gated)
		else $error("pulse up set without enable");

	property p_reg_rst;
		s_rst_req |=> s_rst_done;
	endproperty
	a_reg_rst: assert property (p_reg_rst)
		else $error("register reset sequence wrong");

	property p_rsvd_read;
		i_reg_rd && i_reg_addr == ADDR_RESERVED |=> o_reg_rdata == 8'h00;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read)
		else $error("reserved register not zero");

endmodule : charger_control_register_bank

// ==== bench/tb_charger_control_register_bank.sv ====
`timescale 1ns/100ps
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
		end \
	end
module tb_charger_control_register_bank;
	import charger_pkg::*;
	// short second and ship delay keep the run near a thousand cycles long
	localparam int SEC_CYC = 20;
	localparam logic [7:0] SHIP_S = 8'h02;
	localparam int LIMIT = 20000;
	logic i_clk;
	logic i_rstn;
	logic [7:0] i_reg_addr;
	logic i_reg_wr;
	logic i_reg_rd;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic i_band_cold, i_band_hot, i_power_limiting, i_thermal_reg;
	logic i_optimizer_started, i_pulse_done;
	logic o_charge_term_enable, o_watchdog_expired, o_safety_timer_enable;
	logic o_safety_timer_half_rate, o_safety_timer_reset;
	logic o_force_optimizer_start, o_battery_switch_off;
	logic o_full_system_reset_enable, o_pulse_up_request, o_pulse_down_request;
	logic [1:0] o_fast_charge_time_limit;
	logic [7:0] o_watchdog_period_s, o_charge_current_pct;
	logic [7:0] o_comp_resistance_mohm, o_comp_voltage_clamp_mv;
	logic [7:0] o_thermal_reg_threshold_c, o_charge_voltage_drop_mv;
	int err_count = 0;
	int total_checks = 0;
	int exp_cnt = 0;
	int srst_cnt = 0;
	int n, base;
	logic [2:0] v;

	////////////////////////////////////////////////////////////////////////
	charger_control_register_bank #(
		.SEC_CYCLES(SEC_CYC),
		.SHIP_DLY_S(SHIP_S)
	) dut_u (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_reg_addr(i_reg_addr),
		.i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd),
		.i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata),
		.i_band_cold(i_band_cold),
		.i_band_hot(i_band_hot),
		.i_power_limiting(i_power_limiting),
		.i_thermal_reg(i_thermal_reg),
		.i_optimizer_started(i_optimizer_started),
		.i_pulse_done(i_pulse_done),
		.o_charge_term_enable(o_charge_term_enable),
		.o_fast_charge_time_limit(o_fast_charge_time_limit),
		.o_watchdog_period_s(o_watchdog_period_s),
		.o_watchdog_expired(o_watchdog_expired),
		.o_safety_timer_enable(o_safety_timer_enable),
		.o_safety_timer_half_rate(o_safety_timer_half_rate),
		.o_safety_timer_reset(o_safety_timer_reset),
		.o_charge_current_pct(o_charge_current_pct),
		.o_comp_resistance_mohm(o_comp_resistance_mohm),
		.o_comp_voltage_clamp_mv(o_comp_voltage_clamp_mv),
		.o_thermal_reg_threshold_c(o_thermal_reg_threshold_c),
		.o_charge_voltage_drop_mv(o_charge_voltage_drop_mv),
		.o_force_optimizer_start(o_force_optimizer_start),
		.o_battery_switch_off(o_battery_switch_off),
		.o_full_system_reset_enable(o_full_system_reset_enable),
		.o_pulse_up_request(o_pulse_up_request),
		.o_pulse_down_request(o_pulse_down_request)
	);

	////////////////////////////////////////////////////////////////////////
	initial i_clk = 1'b0;
	always #2.5 i_clk = ~i_clk;

	// one-cycle pulses are counted here so no test can miss them
	always @(posedge i_clk)
	begin
		if (o_watchdog_expired === 1'b1)
			exp_cnt++;
		if (o_safety_timer_reset === 1'b1)
			srst_cnt++;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (LIMIT) @(posedge i_clk);
		err_count++;
		$display("CHECK FAILED t=%0t run did not finish", $time);
		test_done();
	end

	task automatic idle(input int c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		idle(1);
		`CHK(o_reg_rdata, e)
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_rstn = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_wdata = 8'h00;
		{i_band_cold, i_band_hot, i_power_limiting, i_thermal_reg} = 4'h0;
		i_optimizer_started = 1'b0;
		i_pulse_done = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rstn <= 1'b1;
		idle(5);
		rd(ADDR_TIMER_COLD, RST_TIMER_COLD);
		rd(ADDR_COMP_THERMAL, RST_COMP_THERMAL);
		rd(ADDR_OPT_SWITCH, RST_OPT_SWITCH);
		rd(ADDR_RESERVED, 8'h00);
		rd(8'h33, 8'h00);
		`CHK(o_safety_timer_enable, 1'b1)
		`CHK(o_full_system_reset_enable, 1'b1)
		`CHK(o_charge_current_pct, 8'h64)
		// reserved positions in every register
		wr(ADDR_TIMER_COLD, 8'hff);
		rd(ADDR_TIMER_COLD, 8'hbf);
		wr(ADDR_RESERVED, 8'hff);
		rd(ADDR_RESERVED, 8'h00);
		wr(ADDR_MISC_CTRL, 8'h7f);
		rd(ADDR_MISC_CTRL, 8'h01);
		idle(3);
		`CHK(o_watchdog_period_s, 8'ha0)
		wr(ADDR_TIMER_COLD, 8'ha5);
		idle(4);
		`CHK(o_watchdog_period_s, 8'h50)
		`CHK(o_safety_timer_enable, 1'b0)
		@(posedge i_clk) i_band_cold <= 1'b1;
		wr(ADDR_TIMER_COLD, 8'h9c);
		idle(6);
		`CHK(o_charge_current_pct, 8'h32)
		wr(ADDR_TIMER_COLD, 8'h9d);
		idle(4);
		`CHK(o_charge_current_pct, 8'h14)
		@(posedge i_clk) i_band_cold <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			v = 3'(i);
			wr(ADDR_COMP_THERMAL, {v, v, v[1:0]});
			idle(4);
			`CHK(o_comp_resistance_mohm, 8'(20 * i))
			`CHK(o_comp_voltage_clamp_mv, 8'(32 * i))
			`CHK(o_thermal_reg_threshold_c, 8'(60 + 20 * (i % 4)))
		end
		// hot band drop and timer slowdown
		@(posedge i_clk) i_band_hot <= 1'b1;
		i_power_limiting <= 1'b1;
		wr(ADDR_OPT_SWITCH, 8'h44);
		idle(6);
		`CHK(o_charge_voltage_drop_mv, 8'hc8)
		`CHK(o_safety_timer_half_rate, 1'b1)
		wr(ADDR_OPT_SWITCH, 8'h14);
		idle(4);
		`CHK(o_charge_voltage_drop_mv, 8'h00)
		`CHK(o_safety_timer_half_rate, 1'b0)
		@(posedge i_clk) i_power_limiting <= 1'b0;
		i_thermal_reg <= 1'b1;
		wr(ADDR_OPT_SWITCH, 8'h44);
		idle(6);
		`CHK(o_safety_timer_half_rate, 1'b1)
		// set-only force bit, cleared by the optimizer start
		wr(ADDR_OPT_SWITCH, 8'hc4);
		idle(2);
		`CHK(o_force_optimizer_start, 1'b1)
		wr(ADDR_OPT_SWITCH, 8'h44);
		rd(ADDR_OPT_SWITCH, 8'hc4);
		@(posedge i_clk) i_optimizer_started <= 1'b1;
		idle(6);
		`CHK(o_force_optimizer_start, 1'b0)
		rd(ADDR_OPT_SWITCH, 8'h44);
		@(posedge i_clk) i_optimizer_started <= 1'b0;
		// pulse requests need the enable first
		wr(ADDR_MISC_CTRL, 8'h00);
		wr(ADDR_OPT_SWITCH, 8'h47);
		rd(ADDR_OPT_SWITCH, 8'h44);
		wr(ADDR_MISC_CTRL, 8'h01);
		wr(ADDR_OPT_SWITCH, 8'h46);
		idle(3);
		`CHK({o_pulse_up_request, o_pulse_down_request}, 2'b10)
		rd(ADDR_OPT_SWITCH, 8'h46);
		@(posedge i_clk) i_pulse_done <= 1'b1;
		idle(6);
		`CHK(o_pulse_up_request, 1'b0)
		@(posedge i_clk) i_pulse_done <= 1'b0;
		wr(ADDR_OPT_SWITCH, 8'h45);
		idle(6);
		`CHK({o_pulse_up_request, o_pulse_down_request}, 2'b01)
		@(posedge i_clk) i_pulse_done <= 1'b1;
		idle(6);
		`CHK(o_pulse_down_request, 1'b0)
		rd(ADDR_OPT_SWITCH, 8'h44);
		@(posedge i_clk) i_pulse_done <= 1'b0;
		// ship mode, immediate then delayed
		wr(ADDR_OPT_SWITCH, 8'h64);
		idle(3);
		`CHK(o_battery_switch_off, 1'b1)
		wr(ADDR_OPT_SWITCH, 8'h44);
		idle(3);
		`CHK(o_battery_switch_off, 1'b0)
		wr(ADDR_OPT_SWITCH, 8'h6c);
		idle(3);
		`CHK(o_battery_switch_off, 1'b0)
		n = 0;
		while (o_battery_switch_off !== 1'b1 && n < 100)
		begin
			idle(1);
			n++;
		end
		`CHK((n > 10 && n < 80), 1'b1)
		// watchdog expiry keeps only the ship group
		wr(ADDR_TIMER_COLD, 8'h13);
		wr(ADDR_COMP_THERMAL, 8'hff);
		wr(ADDR_OPT_SWITCH, 8'h2c);
		idle(3);
		`CHK({o_charge_term_enable, o_fast_charge_time_limit}, 3'b001)
		n = 0;
		while (exp_cnt == 0 && n < 1200)
		begin
			idle(1);
			n++;
		end
		`CHK((exp_cnt == 1 && n > 770), 1'b1)
		idle(2);
		rd(ADDR_COMP_THERMAL, RST_COMP_THERMAL);
		rd(ADDR_OPT_SWITCH, 8'h6c);
		rd(ADDR_MISC_CTRL, 8'h00);
		rd(ADDR_TIMER_COLD, RST_TIMER_COLD);
		`CHK({o_charge_term_enable, o_fast_charge_time_limit}, 3'b110)
		// register reset restores everything and self-clears
		base = srst_cnt;
		wr(ADDR_MISC_CTRL, 8'h80);
		idle(4);
		`CHK(srst_cnt - base, 1)
		rd(ADDR_OPT_SWITCH, RST_OPT_SWITCH);
		rd(ADDR_MISC_CTRL, 8'h00);
		`CHK(o_battery_switch_off, 1'b0)
		test_done();
	end
endmodule : tb_charger_control_register_bank
